// *** pkg/slp_regs.svh ***
`ifndef SLP_REGS_SVH
`define SLP_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SLP_OFF_SELECT 8'h00
`define SLP_OFF_OVS1 8'h04
`define SLP_OFF_TRQ2 8'h08
`define SLP_OFF_DEV2 8'h0C
`define SLP_OFF_OVS2 8'h10
`define SLP_OFF_STATUS 8'h14
`define SLP_OFF_DIV 8'h18
// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define SLP_RST_SELECT 4'h0
`define SLP_RST_OVS1 13'h0000
`define SLP_RST_TRQ2 10'h000
`define SLP_RST_DEV2 15'h0753
`define SLP_RST_OVS2 13'h0000
`define SLP_RST_DIV 16'h0000
`define SLP_SWITCH_ON 4'h2
`define SLP_OVS_MAX 13'h1770
`define SLP_TRQ_MAX 10'h1F4
`define SLP_DEV_MIN 15'h0001
// ----------------------------------------
// timing
// ----------------------------------------
`define SLP_CLR_MS 120
`define SLP_CLK_KHZ 250000
`define SLP_CLR_CYCLES (`SLP_CLR_MS * `SLP_CLK_KHZ)
`define SLP_ZSTRETCH 16
`endif

// *** pkg/slp_pkg.sv ***
package slp_pkg;
   typedef struct packed {
      logic a;
      logic b;
      logic z;
   } slp_phase_t;
   typedef struct packed {
      logic [12:0] speed;
      logic [9:0] torque_req;
      logic [23:0] deviation;
   } slp_motor_t;
   typedef enum logic [1:0] {
      SLP_RESP_OKAY = 2'h0,
      SLP_RESP_SLVERR = 2'h2
   } slp_resp_t;
endpackage

// *** rtl/slp_encoder_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "slp_regs.svh"
module slp_encoder_divider
   import slp_pkg::*;
#(
   parameter int DIV_W = 16,
   parameter int Z_W = `SLP_ZSTRETCH
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   // control
   input wire logic [DIV_W-1:0] div_in,
   // phases
   input wire slp_phase_t phase_in,
   output slp_phase_t phase_out,
   output logic z_wide_out
);
   logic [DIV_W-1:0] cnt_q;
   logic a_prev_q;
   logic [7:0] zcnt_q;
   wire a_edge = phase_in.a != a_prev_q;
   wire wrap = cnt_q >= div_in;
   // ----------------------------------------
   // divide a/b by div_in+1 on edges of a
   // ----------------------------------------
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         cnt_q <= '0;
         a_prev_q <= 1'b0;
         phase_out <= '0;
         zcnt_q <= 8'h00;
         z_wide_out <= 1'b0;
      end else begin
         a_prev_q <= phase_in.a;
         phase_out.z <= phase_in.z;
         if (a_edge) begin
            cnt_q <= wrap ? '0 : cnt_q + 1'b1;
            if (wrap) begin
               phase_out.a <= ~phase_out.a;
               phase_out.b <= phase_in.b;
            end
         end
         // stretch z so a slow receiver catches it
         if (phase_in.z) begin
            zcnt_q <= 8'(Z_W - 1);
         end else if (zcnt_q != 8'h00) begin
            zcnt_q <= zcnt_q - 8'h01;
         end
         z_wide_out <= phase_in.z || (zcnt_q != 8'h00);
      end
   end
endmodule
`default_nettype wire

// *** rtl/slp_top.sv ***
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "slp_regs.svh"
module slp_top
   import slp_pkg::*;
#(
   parameter int CLR_CYCLES = `SLP_CLR_CYCLES,
   parameter int DIV_W = 16
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // motor side
   input wire slp_motor_t motor_in,
   input wire logic torque_set2_sel_in,
   input wire logic [9:0] torque_limit1_in,
   input wire logic [14:0] deviation_range1_in,
   output logic [9:0] torque_limit_out,
   output logic overspeed_err_out,
   output logic deviation_err_out,
   // host pins
   input wire logic alarm_clear_input_n_in,
   input wire slp_phase_t enc_in,
   output slp_phase_t enc_p_out,
   output slp_phase_t enc_n_out,
   output logic z_oc_out,
   output logic z_oc_oe_n_out
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [3:0] select_q;
   logic [12:0] ovs1_q, ovs2_q;
   logic [9:0] trq2_q;
   logic [14:0] dev2_q;
   logic [DIV_W-1:0] div_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic aw_have_q, w_have_q;
   logic [2:0] clr_sync_q;
   logic clr_level_q;
   logic [31:0] clr_cnt_q;
   logic clr_pulse_q;
   slp_phase_t div_ph;
   logic z_wide;
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (reset_in);
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction
   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire sw_on = select_q == `SLP_SWITCH_ON;
   wire set2 = sw_on && torque_set2_sel_in;
   wire [12:0] ovs_lvl = set2 ? ovs2_q : ovs1_q;
   wire [9:0] trq_lim = set2 ? trq2_q : torque_limit1_in;
   wire [14:0] dev_lim = sw_on ? dev2_q : deviation_range1_in;
   wire [23:0] dev_thr = {1'b0, dev_lim, 8'h00};
   wire ovs_hit = sw_on && (motor_in.speed > ovs_lvl);
   wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;
   wire [31:0] wm = merge(32'h0000_0000, wdata_q, wstrb_q);
   wire wr_hit = wr_hit_r(awaddr_q) && awaddr_q != `SLP_OFF_STATUS;
   wire [7:0] ra = s_axi_araddr;
   wire rd_hit = wr_hit_r(ra);
   wire [31:0] rd_val =
      ra == `SLP_OFF_SELECT ? {28'h0, select_q} :
      ra == `SLP_OFF_OVS1 ? {19'h0, ovs1_q} :
      ra == `SLP_OFF_TRQ2 ? {22'h0, trq2_q} :
      ra == `SLP_OFF_DEV2 ? {17'h0, dev2_q} :
      ra == `SLP_OFF_OVS2 ? {19'h0, ovs2_q} :
      ra == `SLP_OFF_DIV ? 32'(div_q) :
      ra == `SLP_OFF_STATUS ? {29'h0, set2, deviation_err_out, overspeed_err_out} :
      32'h0000_0000;
   function automatic logic wr_hit_r(input logic [7:0] a);
      return a == `SLP_OFF_SELECT || a == `SLP_OFF_OVS1 || a == `SLP_OFF_TRQ2 ||
             a == `SLP_OFF_DEV2 || a == `SLP_OFF_OVS2 || a == `SLP_OFF_DIV ||
             a == `SLP_OFF_STATUS;
   endfunction
   // ----------------------------------------
   // axi4-lite slave
   // ----------------------------------------
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? SLP_RESP_OKAY : SLP_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? SLP_RESP_OKAY : SLP_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
   // ----------------------------------------
   // settings, with ovs1, ovs2, trq2 and dev2 clamped to their ranges
   // ----------------------------------------
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         select_q <= `SLP_RST_SELECT;
         ovs1_q <= `SLP_RST_OVS1;
         trq2_q <= `SLP_RST_TRQ2;
         dev2_q <= `SLP_RST_DEV2;
         ovs2_q <= `SLP_RST_OVS2;
         div_q <= DIV_W'(`SLP_RST_DIV);
      end else if (do_write) begin
         case (awaddr_q)
            `SLP_OFF_SELECT: select_q <= wm[3:0];
            `SLP_OFF_OVS1: ovs1_q <= wm[12:0] > `SLP_OVS_MAX ? `SLP_OVS_MAX : wm[12:0];
            `SLP_OFF_TRQ2: trq2_q <= wm[9:0] > `SLP_TRQ_MAX ? `SLP_TRQ_MAX : wm[9:0];
            `SLP_OFF_DEV2: dev2_q <= wm[14:0] < `SLP_DEV_MIN ? `SLP_DEV_MIN : wm[14:0];
            `SLP_OFF_OVS2: ovs2_q <= wm[12:0] > `SLP_OVS_MAX ? `SLP_OVS_MAX : wm[12:0];
            `SLP_OFF_DIV: div_q <= wm[DIV_W-1:0];
            default: ;
         endcase
      end
   end
   // ----------------------------------------
   // alarm clear filter
   // ----------------------------------------
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         clr_sync_q <= 3'h0;
         clr_level_q <= 1'b0;
         clr_cnt_q <= 32'h0000_0000;
         clr_pulse_q <= 1'b0;
      end else begin
         clr_sync_q <= {clr_sync_q[1:0], !alarm_clear_input_n_in};
         if (clr_sync_q[2] == clr_sync_q[1]) clr_level_q <= clr_sync_q[2];
         clr_pulse_q <= 1'b0;
         if (!clr_level_q) begin
            clr_cnt_q <= 32'h0000_0000;
         end else if (clr_cnt_q < 32'(CLR_CYCLES)) begin
            clr_cnt_q <= clr_cnt_q + 32'h0000_0001;
            clr_pulse_q <= clr_cnt_q == 32'(CLR_CYCLES - 1);
         end
      end
   end
   // ----------------------------------------
   // protection outputs
   // ----------------------------------------
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         overspeed_err_out <= 1'b0;
         deviation_err_out <= 1'b0;
         torque_limit_out <= 10'h000;
      end else begin
         torque_limit_out <= trq_lim;
         // set wins over clear
         if (ovs_hit) overspeed_err_out <= 1'b1;
         else if (clr_pulse_q) overspeed_err_out <= 1'b0;
         if (motor_in.deviation > dev_thr) deviation_err_out <= 1'b1;
         else if (clr_pulse_q) deviation_err_out <= 1'b0;
      end
   end
   // ----------------------------------------
   // encoder outputs
   // ----------------------------------------
   slp_encoder_divider #(.DIV_W(DIV_W), .Z_W(`SLP_ZSTRETCH)) u_div (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .div_in(div_q),
      .phase_in(enc_in),
      .phase_out(div_ph),
      .z_wide_out(z_wide)
   );
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         enc_p_out <= '0;
         enc_n_out <= '1;
         z_oc_out <= 1'b0;
         z_oc_oe_n_out <= 1'b1;
      end else begin
         enc_p_out <= div_ph;
         enc_n_out <= ~div_ph;
         z_oc_out <= 1'b0;
         z_oc_oe_n_out <= !z_wide;
      end
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_ovs_latch;
      ovs_hit |=> overspeed_err_out;
   endproperty
   a_ovs_latch: assert property (p_ovs_latch) else $error("overspeed not latched");
   property p_ovs_hold;
      overspeed_err_out && !clr_pulse_q |=> overspeed_err_out;
   endproperty
   a_ovs_hold: assert property (p_ovs_hold) else $error("overspeed dropped");
   property p_trq2;
      set2 |=> torque_limit_out == $past(trq2_q);
   endproperty
   a_trq2: assert property (p_trq2) else $error("torque cap wrong");
   property p_off;
      !sw_on && !overspeed_err_out |=> !overspeed_err_out;
   endproperty
   a_off: assert property (p_off) else $error("overspeed while disabled");
   property p_set2_lvl;
      set2 && motor_in.speed > ovs2_q |=> overspeed_err_out;
   endproperty
   a_set2_lvl: assert property (p_set2_lvl) else $error("second level ignored");
   property p_dev;
      sw_on && motor_in.deviation > {1'b0, dev2_q, 8'h00} |=> deviation_err_out;
   endproperty
   a_dev: assert property (p_dev) else $error("deviation not flagged");
   property p_clr;
      clr_pulse_q |-> clr_cnt_q == 32'(CLR_CYCLES) && $past(clr_level_q);
   endproperty
   alarm_clear_input: assert property (p_clr) else $error("clear too early");
   property p_diff;
      enc_p_out == ~enc_n_out;
   endproperty
   a_diff: assert property (p_diff) else $error("pair not complementary");
   property p_z;
      div_ph.z |-> ##2 !z_oc_oe_n_out;
   endproperty
   a_z: assert property (p_z) else $error("z not on open collector");
endmodule
`default_nettype wire

// *** test/slp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module slp_host_model
   import slp_pkg::*;
(
   // clock
   input wire logic core_clk_in,
   // encoder receivers
   input wire slp_phase_t enc_p_in,
   input wire slp_phase_t enc_n_in,
   input wire logic z_oc_in,
   input wire logic z_oc_oe_n_in,
   // alarm clear contact
   output logic alarm_clear_n_out,
   // observations
   output int a_toggles_out,
   output int z_width_out,
   output logic pair_bad_out
);
   // ----------------------------------------
   // host side receivers
   // ----------------------------------------
   logic z_line;
   logic a_q;
   int run;
   // open collector line with pull-up
   assign z_line = z_oc_oe_n_in ? 1'b1 : z_oc_in;
   initial begin
      alarm_clear_n_out = 1'b1;
      a_toggles_out = 0;
      z_width_out = 0;
      pair_bad_out = 1'b0;
      run = 0;
      a_q = 1'b0;
   end
   always @(posedge core_clk_in) begin
      a_q <= enc_p_in.a;
      if (enc_p_in.a !== a_q) a_toggles_out <= a_toggles_out + 1;
      if (enc_n_in !== ~enc_p_in) pair_bad_out <= 1'b1;
      if (!z_line) run <= run + 1;
      else if (run != 0) begin
         z_width_out <= run;
         run <= 0;
      end
   end
   // contact closed for the given count of cycles
   task automatic hold_clear(input int cyc);
      @(posedge core_clk_in);
      alarm_clear_n_out <= 1'b0;
      repeat (cyc) @(posedge core_clk_in);
      alarm_clear_n_out <= 1'b1;
      @(posedge core_clk_in);
   endtask
endmodule
`default_nettype wire

// *** test/test_slp_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_slp_top
   import slp_pkg::*;
();
   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   localparam int CLR = 20;
   logic core_clk_in, reset_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   slp_motor_t motor;
   slp_phase_t enc, enc_p, enc_n;
   logic set2, ovs, dev, clr_n, z_oc, z_oe_n, pair_bad;
   logic [9:0] lim1, torque;
   logic [14:0] rng1;
   int a_tog, z_w, n_errors, check_count, i, a0;
   integer seed;
   logic [1:0] bq[$];
   logic [33:0] rq[$];
   logic [31:0] dflt [0:6] = '{32'h0, 32'h0, 32'h0, 32'h0753, 32'h0, 32'h0, 32'h0};
   slp_top #(.CLR_CYCLES(CLR)) DUT (
      .core_clk_in, .reset_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .motor_in(motor), .torque_set2_sel_in(set2),
      .torque_limit1_in(lim1), .deviation_range1_in(rng1), .torque_limit_out(torque),
      .overspeed_err_out(ovs), .deviation_err_out(dev), .alarm_clear_input_n_in(clr_n),
      .enc_in(enc), .enc_p_out(enc_p), .enc_n_out(enc_n), .z_oc_out(z_oc),
      .z_oc_oe_n_out(z_oe_n));
   slp_host_model host (
      .core_clk_in, .enc_p_in(enc_p), .enc_n_in(enc_n), .z_oc_in(z_oc), .z_oc_oe_n_in(z_oe_n),
      .alarm_clear_n_out(clr_n), .a_toggles_out(a_tog), .z_width_out(z_w),
      .pair_bad_out(pair_bad));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bq.push_back(er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk_in);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      @(posedge core_clk_in);
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] exp);
      rq.push_back(exp);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk_in);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge core_clk_in);
   endtask
   task automatic settle;
      repeat (4) @(posedge core_clk_in);
   endtask
   task automatic toggles(input int n);
      repeat (n) begin
         enc.a <= ~enc.a;
         enc.b <= 1'($random(seed));
         repeat (4) @(posedge core_clk_in);
      end
      settle;
   endtask
   // ----------------------------------------
   // response watcher and sequence
   // ----------------------------------------
   always @(posedge core_clk_in) begin
      if (s_axi_bvalid && s_axi_bready) begin
         check("bresp", {32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
      end
      if (s_axi_rvalid && s_axi_rready) begin
         check("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
      end
   end
   initial begin
      core_clk_in = 1'b0;
      forever #2 core_clk_in = ~core_clk_in;
   end
   initial begin
      #80000;
      n_errors++;
      end_sim;
   end
   initial begin
      seed = 32'h0000_024E;
      reset_in = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      motor = '0;
      enc = '0;
      {set2, lim1, rng1} = 26'h0;
      repeat (3) @(posedge core_clk_in);
      reset_in <= 1'b0;
      for (i = 0; i < 7; i++) rd(8'(i * 4), {2'h0, dflt[i]});
      rd(8'h1C, {2'h2, 32'h0});
      wr(8'h1C, 32'h0000_0001, 2'h2);
      $display("test defaults done");
      wr(8'h04, 32'h0000_1B58, 2'h0);
      rd(8'h04, {2'h0, 32'h0000_1770});
      wr(8'h08, 32'h0000_0258, 2'h0);
      rd(8'h08, {2'h0, 32'h0000_01F4});
      wr(8'h0C, 32'h0, 2'h0);
      rd(8'h0C, {2'h0, 32'h0000_0001});
      wr(8'h04, 32'h0000_0064, 2'h0);
      wr(8'h08, 32'h0000_00C8, 2'h0);
      s_axi_wstrb <= 4'h1;
      wr(8'h0C, 32'h0000_FF02, 2'h0);
      s_axi_wstrb <= 4'hF;
      rd(8'h0C, {2'h0, 32'h0000_0002});
      wr(8'h10, 32'h0000_012C, 2'h0);
      wr(8'h00, 32'h0000_0001, 2'h0);
      $display("test limits done");
      set2 <= 1'b1;
      lim1 <= 10'h032;
      rng1 <= 15'h000A;
      motor.deviation <= 24'h000258;
      repeat (8) begin
         motor.speed <= 13'($unsigned($random(seed)) % 6000);
         @(posedge core_clk_in);
      end
      settle;
      check("torque", {24'h0, torque}, 34'h032);
      rd(8'h14, {2'h0, 32'h0});
      motor.speed <= 13'h00FA;
      motor.deviation <= 24'h0001F4;
      wr(8'h00, 32'h0000_0002, 2'h0);
      settle;
      check("torque", {24'h0, torque}, 34'h0C8);
      rd(8'h14, {2'h0, 32'h0000_0004});
      set2 <= 1'b0;
      motor.speed <= 13'h0064;
      settle;
      check("torque", {24'h0, torque}, 34'h032);
      rd(8'h14, {2'h0, 32'h0});
      motor.speed <= 13'h0065;
      settle;
      rd(8'h14, {2'h0, 32'h0000_0001});
      motor.speed <= 13'h0000;
      settle;
      rd(8'h14, {2'h0, 32'h0000_0001});
      host.hold_clear(CLR / 2);
      settle;
      rd(8'h14, {2'h0, 32'h0000_0001});
      host.hold_clear(CLR + 10);
      settle;
      rd(8'h14, {2'h0, 32'h0});
      $display("test first set done");
      set2 <= 1'b1;
      motor.speed <= 13'h012D;
      settle;
      rd(8'h14, {2'h0, 32'h0000_0005});
      motor.deviation <= 24'h000208;
      settle;
      rd(8'h14, {2'h0, 32'h0000_0007});
      check("errs", {32'h0, dev, ovs}, 34'h3);
      motor <= '0;
      host.hold_clear(CLR + 10);
      settle;
      rd(8'h14, {2'h0, 32'h0000_0004});
      $display("test second set done");
      wr(8'h18, 32'h0, 2'h0);
      a0 = a_tog;
      toggles(8);
      check("div0", 34'(a_tog - a0), 34'h8);
      wr(8'h18, 32'h0000_0001, 2'h0);
      a0 = a_tog;
      toggles(8);
      check("div1", 34'(a_tog - a0), 34'h4);
      enc.z <= 1'b1;
      @(posedge core_clk_in);
      enc.z <= 1'b0;
      repeat (30) @(posedge core_clk_in);
      check("zwidth", 34'(z_w), 34'h10);
      check("pair", {33'h0, pair_bad}, 34'h0);
      $display("test encoder done");
      end_sim;
   end
endmodule
`default_nettype wire
